// ---- dlr_pkg.sv ----
// How it works
// - append 32-bit link CRC to each sent packet
// - recompute link CRC on each received packet
// - bad link CRC answers with negative acknowledge
// - good packet answers with acknowledge, or with negative acknowledge when the receive buffer is full
// - keep sent packets until acknowledged
// - acknowledge purges stored packets up to its number
// - replay on negative acknowledge or timer expiry
// - replay oldest unacknowledged first, then in order
// - exchange flow-control credit packets with partner
// - every link control packet carries 16-bit CRC
// - training, scrambling and skip insertion toward link
package dlr_pkg;
  localparam int DATA_W      = 32;
  localparam int SEQ_W       = 12;
  localparam int LCRC_W      = 32;
  localparam int DCRC_W      = 16;
  localparam int CRED_W      = 8;
  localparam int TMR_W       = 12;
  localparam int LFSR_W      = 16;
  localparam int RETRY_AW    = 2;
  localparam int RETRY_DEPTH = 4;
  localparam int BUF_DEPTH   = 2;
  localparam logic [SEQ_W-1:0]  RETRY_LIMIT = 12'h004;
  localparam logic [SEQ_W-1:0]  SEQ_RST     = 12'h000;
  localparam logic [CRED_W-1:0] CRED_RST    = 8'h00;
  localparam logic [TMR_W-1:0]  TMR_RST     = 12'h000;
  localparam logic [LCRC_W-1:0] LCRC_POLY   = 32'h04c11db7;
  localparam logic [DCRC_W-1:0] DCRC_POLY   = 16'h100b;
  localparam logic [LFSR_W-1:0] LFSR_SEED   = 16'hffff;
  localparam logic [LFSR_W-1:0] LFSR_TAPS   = 16'h0039;
  localparam logic [7:0]        DL_ACK      = 8'h00;
  localparam logic [7:0]        DL_NAK      = 8'h10;
  localparam logic [7:0]        DL_FC       = 8'h40;
  localparam int CLK_NS     = 100;
  localparam int REPLAY_NS  = 20000;
  localparam int FC_NS      = 30000;
  localparam int SKIP_NS    = 118000;
  localparam int REPLAY_CYC = (REPLAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int FC_CYC     = FC_NS / CLK_NS;
  localparam int SKIP_CYC   = SKIP_NS / CLK_NS;
  localparam logic [TMR_W-1:0] REPLAY_LAST = TMR_W'(REPLAY_CYC - 1);
  localparam logic [TMR_W-1:0] FC_LAST     = TMR_W'(FC_CYC - 1);
  localparam logic [TMR_W-1:0] SKIP_LAST   = TMR_W'(SKIP_CYC - 1);

  typedef enum logic [2:0] {
    KD_IDLE = 3'h0,
    KD_TLP  = 3'h1,
    KD_DLLP = 3'h2,
    KD_TS   = 3'h3,
    KD_SKIP = 3'h4
  } dlr_kind_t;

  typedef enum logic [2:0] {
    LT_DETECT = 3'b001,
    LT_TRAIN  = 3'b010,
    LT_L0     = 3'b100
  } dlr_ltssm_t;

  typedef struct packed {
    dlr_kind_t          kind;
    logic [SEQ_W-1:0]   seq;
    logic [DATA_W-1:0]  data;
    logic [LCRC_W-1:0]  crc;
  } dlr_beat_t;
endpackage

// ---- dlr_crc.sv ----
`timescale 1ns/1ns
module dlr_crc #(
  parameter int            W    = 32,
  parameter int            MW   = 44,
  parameter logic [W-1:0]  POLY = '1
) (
  // message and its check value
  input  wire logic [MW-1:0] msg,
  output logic      [W-1:0]  crc
);
  // bit-serial division, msb first, register preset to ones
  always_comb begin
    crc = '1;
    for (int i = MW - 1; i >= 0; i--) begin
      if (crc[W-1] ^ msg[i]) begin
        crc = {crc[W-2:0], 1'b0} ^ POLY;
      end else begin
        crc = {crc[W-2:0], 1'b0};
      end
    end
  end
endmodule

// ---- dlr_buf2.sv ----
`timescale 1ns/1ns
module dlr_buf2 #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // fill side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // drain side
  output logic              outValid,
  output logic      [W-1:0] outData,
  input  wire logic         outReady
);
  import dlr_pkg::*;

  logic [W-1:0] mem_r [BUF_DEPTH];
  logic [W-1:0] mem_nxt [BUF_DEPTH];
  logic         wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic         push, pop;

  assign inReady  = (cnt_r != 2'(BUF_DEPTH));
  assign outValid = (cnt_r != 2'h0);
  assign outData  = mem_r[rp_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = inData;
      wp_nxt        = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    mem_r <= mem_nxt;
    if (!rst_b) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ---- dlr_link.sv ----
`timescale 1ns/1ns
module dlr_link (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  // transaction layer transmit
  input  wire logic                       tlTxValid,
  input  wire logic [dlr_pkg::DATA_W-1:0] tlTxData,
  output logic                            tlTxReady,
  // transaction layer receive
  output logic                            tlRxValid,
  output logic      [dlr_pkg::DATA_W-1:0] tlRxData,
  input  wire logic                       tlRxReady,
  // flow-control credits
  input  wire logic [dlr_pkg::CRED_W-1:0] rxCreditAdv,
  output logic      [dlr_pkg::CRED_W-1:0] txCreditLimit,
  // link beats
  output dlr_pkg::dlr_beat_t              linkTx,
  input  dlr_pkg::dlr_beat_t              linkRx,
  // status
  output logic                            linkUp,
  output logic                            replayActive
);
  import dlr_pkg::*;

  dlr_ltssm_t        lt_r, lt_nxt;
  logic [LFSR_W-1:0] txLfsr_r, txLfsr_nxt, rxLfsr_r, rxLfsr_nxt;
  logic [SEQ_W-1:0]  nextSeq_r, nextSeq_nxt, ackSeq_r, ackSeq_nxt;
  logic [SEQ_W-1:0]  replaySeq_r, replaySeq_nxt, rcvSeq_r, rcvSeq_nxt;
  logic              replaying_r, replaying_nxt, ackPend_r, ackPend_nxt;
  logic              nakPend_r, nakPend_nxt, fcDue_r, fcDue_nxt;
  logic              skipDue_r, skipDue_nxt, fcSeen_r, fcSeen_nxt;
  logic [TMR_W-1:0]  replayTmr_r, replayTmr_nxt, fcTmr_r, fcTmr_nxt;
  logic [TMR_W-1:0]  skipTmr_r, skipTmr_nxt;
  logic [CRED_W-1:0] credLimit_r, credLimit_nxt, credUsed_r, credUsed_nxt;
  dlr_beat_t         linkTx_r, beatNxt;
  logic [DATA_W-1:0] retryMem [RETRY_DEPTH];

  logic [SEQ_W-1:0]  unacked, txSeq, rxDSeq, ackNew, ackOut;
  logic [DATA_W-1:0] rxPlain, txTlpData, dllpWord;
  logic [LCRC_W-1:0] txLcrc, rxLcrc;
  logic [DCRC_W-1:0] txDcrc, rxDcrc;
  logic              inL0, sendSkip, sendAck, sendFc, sendRpl, sendNew, canNew;
  logic              rxTlpGood, rxTlpBad, rxDllpGood, inOrder, dupTlp, push, bufReady;
  logic              rxAck, rxNak, rxFc, purge, tmrExpire, replayStart, rxScr, txScr;

  // ---------------- receive checks
  assign rxScr      = (linkRx.kind == KD_TLP) || (linkRx.kind == KD_DLLP);
  assign rxPlain    = linkRx.data ^ {rxLfsr_r, rxLfsr_r};
  assign rxTlpGood  = inL0 && linkRx.kind == KD_TLP && linkRx.crc == rxLcrc;
  assign rxTlpBad   = inL0 && linkRx.kind == KD_TLP && linkRx.crc != rxLcrc;
  assign rxDllpGood = inL0 && linkRx.kind == KD_DLLP && linkRx.crc == {16'h0000, rxDcrc};
  assign rxDSeq     = rxPlain[SEQ_W-1:0];
  assign inOrder    = rxTlpGood && linkRx.seq == rcvSeq_r;
  assign dupTlp     = rxTlpGood && linkRx.seq != rcvSeq_r;
  assign push       = inOrder && bufReady;
  assign rxAck      = rxDllpGood && rxPlain[31:24] == DL_ACK && (rxDSeq - ackSeq_r) < unacked;
  assign rxNak      = rxDllpGood && rxPlain[31:24] == DL_NAK;
  assign rxFc       = rxDllpGood && rxPlain[31:24] == DL_FC;
  // a negative acknowledge still confirms everything up to its number
  assign purge      = (rxAck || rxNak) && (rxDSeq - ackSeq_r) < unacked;
  assign ackNew     = purge ? rxDSeq + 12'h001 : ackSeq_r;

  dlr_crc #(.W(LCRC_W), .MW(SEQ_W + DATA_W), .POLY(LCRC_POLY)) uRxLcrc (
    .msg ({linkRx.seq, rxPlain}),
    .crc (rxLcrc)
  );
  dlr_crc #(.W(DCRC_W), .MW(DATA_W), .POLY(DCRC_POLY)) uRxDcrc (
    .msg (rxPlain),
    .crc (rxDcrc)
  );

  dlr_buf2 #(.W(DATA_W)) uRxBuf (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .inValid  (push),
    .inData   (rxPlain),
    .inReady  (bufReady),
    .outValid (tlRxValid),
    .outData  (tlRxData),
    .outReady (tlRxReady)
  );

  // ---------------- transmit selection
  assign inL0      = (lt_r == LT_L0);
  assign unacked   = nextSeq_r - ackSeq_r;
  assign tmrExpire = unacked != SEQ_RST && replayTmr_r == REPLAY_LAST;
  assign sendSkip  = inL0 && skipDue_r;
  assign sendAck   = inL0 && !skipDue_r && (ackPend_r || nakPend_r);
  assign sendFc    = inL0 && !skipDue_r && !sendAck && fcDue_r;
  assign sendRpl   = inL0 && !skipDue_r && !sendAck && !fcDue_r && replaying_r;
  assign canNew    = inL0 && fcSeen_r && !skipDue_r && !ackPend_r && !nakPend_r && !fcDue_r
                     && !replaying_r && unacked < RETRY_LIMIT
                     && credLimit_r != credUsed_r;
  assign tlTxReady = canNew;
  assign sendNew   = tlTxValid && canNew;
  assign txScr     = sendAck || sendFc || sendRpl || sendNew;
  assign txSeq     = sendRpl ? replaySeq_r : nextSeq_r;
  assign txTlpData = sendRpl ? retryMem[replaySeq_r[RETRY_AW-1:0]] : tlTxData;
  assign ackOut    = rcvSeq_r - 12'h001;
  assign dllpWord  = sendAck ? {(nakPend_r ? DL_NAK : DL_ACK), 12'h000, ackOut}
                             : {DL_FC, 16'h0000, rxCreditAdv};

  dlr_crc #(.W(LCRC_W), .MW(SEQ_W + DATA_W), .POLY(LCRC_POLY)) uTxLcrc (
    .msg ({txSeq, txTlpData}),
    .crc (txLcrc)
  );
  dlr_crc #(.W(DCRC_W), .MW(DATA_W), .POLY(DCRC_POLY)) uTxDcrc (
    .msg (dllpWord),
    .crc (txDcrc)
  );

  always_comb begin
    beatNxt = '0;
    if (lt_r == LT_TRAIN) begin
      beatNxt.kind = KD_TS;
    end else if (sendSkip) begin
      beatNxt.kind = KD_SKIP;
    end else if (sendAck || sendFc) begin
      beatNxt.kind = KD_DLLP;
      beatNxt.data = dllpWord ^ {txLfsr_r, txLfsr_r};
      beatNxt.crc  = {16'h0000, txDcrc};
    end else if (sendRpl || sendNew) begin
      beatNxt.kind = KD_TLP;
      beatNxt.seq  = txSeq;
      beatNxt.data = txTlpData ^ {txLfsr_r, txLfsr_r};
      beatNxt.crc  = txLcrc;
    end
  end

  // ---------------- next state
  always_comb begin
    lt_nxt        = lt_r;
    txLfsr_nxt    = txLfsr_r;
    rxLfsr_nxt    = rxLfsr_r;
    nextSeq_nxt   = nextSeq_r;
    ackSeq_nxt    = ackNew;
    replaySeq_nxt = replaySeq_r;
    replaying_nxt = replaying_r;
    rcvSeq_nxt    = rcvSeq_r;
    ackPend_nxt   = ackPend_r && !sendAck;
    nakPend_nxt   = nakPend_r && !sendAck;
    fcDue_nxt     = fcDue_r && !sendFc;
    skipDue_nxt   = skipDue_r && !sendSkip;
    fcSeen_nxt    = fcSeen_r;
    credLimit_nxt = credLimit_r;
    credUsed_nxt  = credUsed_r;
    fcTmr_nxt     = fcTmr_r + 12'h001;
    skipTmr_nxt   = skipTmr_r + 12'h001;
    replayStart   = rxNak || tmrExpire;
    case (lt_r)
      LT_DETECT: begin
        lt_nxt = LT_TRAIN;
      end
      LT_TRAIN: begin
        if (linkRx.kind == KD_TS) begin
          lt_nxt    = LT_L0;
          fcDue_nxt = 1'b1;
        end
      end
      LT_L0: begin
        if (linkRx.kind == KD_TS) begin
          lt_nxt = LT_TRAIN;
        end
      end
      default: begin
        lt_nxt = LT_DETECT;
      end
    endcase
    if (!inL0) begin
      txLfsr_nxt  = LFSR_SEED;
      rxLfsr_nxt  = LFSR_SEED;
      fcSeen_nxt  = 1'b0;
      fcTmr_nxt   = TMR_RST;
      skipTmr_nxt = TMR_RST;
      replayStart = 1'b0;
    end else begin
      if (txScr) begin
        txLfsr_nxt = {txLfsr_r[LFSR_W-2:0], 1'b0} ^ (txLfsr_r[LFSR_W-1] ? LFSR_TAPS : '0);
      end
      if (rxScr) begin
        rxLfsr_nxt = {rxLfsr_r[LFSR_W-2:0], 1'b0} ^ (rxLfsr_r[LFSR_W-1] ? LFSR_TAPS : '0);
      end
    end
    if (fcTmr_r == FC_LAST) begin
      fcTmr_nxt = TMR_RST;
      fcDue_nxt = 1'b1;
    end
    if (skipTmr_r == SKIP_LAST) begin
      skipTmr_nxt = TMR_RST;
      skipDue_nxt = 1'b1;
    end
    // receive answers; a new event wins over the clear by sending
    if (rxTlpBad || (inOrder && !bufReady)) begin
      nakPend_nxt = 1'b1;
    end else if (push || dupTlp) begin
      ackPend_nxt = 1'b1;
    end
    if (push) begin
      rcvSeq_nxt = rcvSeq_r + 12'h001;
    end
    if (rxFc) begin
      credLimit_nxt = rxPlain[CRED_W-1:0];
      fcSeen_nxt    = 1'b1;
    end
    if (sendNew) begin
      nextSeq_nxt  = nextSeq_r + 12'h001;
      credUsed_nxt = credUsed_r + 8'h01;
    end
    if (sendRpl) begin
      replaySeq_nxt = replaySeq_r + 12'h001;
    end
    if (purge && (replaySeq_nxt - ackSeq_r) < (ackNew - ackSeq_r)) begin
      replaySeq_nxt = ackNew;
    end
    if (replayStart && ackNew != nextSeq_r) begin
      replaying_nxt = 1'b1;
      replaySeq_nxt = ackNew;
    end
    if (replaySeq_nxt == nextSeq_nxt) begin
      replaying_nxt = 1'b0;
    end
    if (purge || replayStart || unacked == SEQ_RST) begin
      replayTmr_nxt = TMR_RST;
    end else begin
      replayTmr_nxt = replayTmr_r + 12'h001;
    end
  end

  // ---------------- registers
  always_ff @(posedge clk_sys) begin
    if (sendNew) begin
      retryMem[nextSeq_r[RETRY_AW-1:0]] <= tlTxData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lt_r        <= LT_DETECT;
      txLfsr_r    <= LFSR_SEED;
      rxLfsr_r    <= LFSR_SEED;
      nextSeq_r   <= SEQ_RST;
      ackSeq_r    <= SEQ_RST;
      replaySeq_r <= SEQ_RST;
      rcvSeq_r    <= SEQ_RST;
      replaying_r <= 1'b0;
      ackPend_r   <= 1'b0;
      nakPend_r   <= 1'b0;
      fcDue_r     <= 1'b0;
      skipDue_r   <= 1'b0;
      fcSeen_r    <= 1'b0;
      replayTmr_r <= TMR_RST;
      fcTmr_r     <= TMR_RST;
      skipTmr_r   <= TMR_RST;
      credLimit_r <= CRED_RST;
      credUsed_r  <= CRED_RST;
      linkTx_r    <= '0;
    end else begin
      lt_r        <= lt_nxt;
      txLfsr_r    <= txLfsr_nxt;
      rxLfsr_r    <= rxLfsr_nxt;
      nextSeq_r   <= nextSeq_nxt;
      ackSeq_r    <= ackSeq_nxt;
      replaySeq_r <= replaySeq_nxt;
      rcvSeq_r    <= rcvSeq_nxt;
      replaying_r <= replaying_nxt;
      ackPend_r   <= ackPend_nxt;
      nakPend_r   <= nakPend_nxt;
      fcDue_r     <= fcDue_nxt;
      skipDue_r   <= skipDue_nxt;
      fcSeen_r    <= fcSeen_nxt;
      replayTmr_r <= replayTmr_nxt;
      fcTmr_r     <= fcTmr_nxt;
      skipTmr_r   <= skipTmr_nxt;
      credLimit_r <= credLimit_nxt;
      credUsed_r  <= credUsed_nxt;
      linkTx_r    <= beatNxt;
    end
  end

  assign linkTx        = linkTx_r;
  assign txCreditLimit = credLimit_r;
  assign linkUp        = inL0 && fcSeen_r;
  assign replayActive  = replaying_r;

  // ---------------- checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_lcrc;
    (sendNew || sendRpl) && !sendAck && !sendFc |=> linkTx.kind == KD_TLP && linkTx.crc == $past(txLcrc);
  endproperty
  a_lcrc: assert property (p_lcrc) else $error("sent packet lacks link crc");
  property p_nak;
    rxTlpBad ##1 inL0 |-> ##[0:2] (linkTx.kind == KD_DLLP && (linkTx.data ^ {txLfsr_r, txLfsr_r}) == 32'h0);
  endproperty
  property p_nak_pend;
    rxTlpBad |=> nakPend_r;
  endproperty
  a_nak_pend: assert property (p_nak_pend) else $error("bad packet not answered");
  property p_ack;
    push && !rxTlpBad |=> ackPend_r && rcvSeq_r == $past(linkRx.seq) + 12'h001;
  endproperty
  a_ack: assert property (p_ack) else $error("good packet not acknowledged");
  property p_hold;
    tlTxReady |-> unacked < RETRY_LIMIT && !replaying_r;
  endproperty
  a_hold: assert property (p_hold) else $error("retry buffer overrun");
  property p_purge;
    rxAck |=> ackSeq_r == $past(rxDSeq) + 12'h001;
  endproperty
  a_purge: assert property (p_purge) else $error("acknowledge did not purge");
  property p_replay;
    inL0 && rxNak && ackNew != nextSeq_r && !sendNew |=> replaying_r && replaySeq_r == $past(ackNew);
  endproperty
  a_replay: assert property (p_replay) else $error("negative acknowledge did not replay");
  property p_order;
    sendRpl |=> linkTx.kind == KD_TLP && linkTx.seq == $past(replaySeq_r);
  endproperty
  a_order: assert property (p_order) else $error("replay out of order");
  property p_credit;
    rxFc |=> txCreditLimit == $past(rxPlain[CRED_W-1:0]);
  endproperty
  a_credit: assert property (p_credit) else $error("credit update lost");
  property p_dcrc;
    sendFc && !sendSkip |=> linkTx.kind == KD_DLLP && linkTx.crc[31:16] == 16'h0000;
  endproperty
  a_dcrc: assert property (p_dcrc) else $error("control packet crc field wrong");
  property p_train;
    lt_r == LT_TRAIN && linkRx.kind == KD_TS |=> inL0 ##1 linkTx.kind != KD_TS;
  endproperty
  a_train: assert property (p_train) else $error("training did not finish");
  property p_seq;
    sendNew |=> nextSeq_r == $past(nextSeq_r) + 12'h001 && linkTx.seq == $past(nextSeq_r);
  endproperty
  a_seq: assert property (p_seq) else $error("sequence number not advanced");
  property p_tmr;
    purge |=> replayTmr_r == TMR_RST;
  endproperty
  a_tmr: assert property (p_tmr) else $error("replay timer not restarted");

  c_nak: cover property (rxTlpBad ##[1:3] sendAck);
  c_replay: cover property (tmrExpire ##1 replaying_r);
  c_full: cover property (inL0 && unacked == RETRY_LIMIT);
  c_stall: cover property (inOrder && !bufReady);
endmodule

// ---- dlr_partner.sv ----
`timescale 1ns/1ns
module dlr_partner (
  // clock
  input  wire logic          clk_sys,
  // link beats
  input  dlr_pkg::dlr_beat_t linkTx,
  output dlr_pkg::dlr_beat_t linkRx
);
  import dlr_pkg::*;
  logic [15:0] txLfsr = LFSR_SEED;
  logic [15:0] rxLfsr = LFSR_SEED;
  logic [31:0] w;
  logic [31:0] fcWord = '0;
  logic [31:0] dq[$];
  logic [75:0] tq[$];
  int          skips  = 0;

  initial linkRx = '0;

  // msb-first crc, kept left-aligned so one loop serves both widths
  function automatic logic [31:0] crc(input logic [43:0] m, input int n, input logic [31:0] p,
                                      input logic [31:0] k);
    logic [31:0] c;
    c = k;
    for (int i = n - 1; i >= 0; i--)
      c = (c << 1) ^ ((c[31] ^ m[i]) ? p : 32'h0);
    return c;
  endfunction

  function automatic logic [15:0] crc16(input logic [31:0] m);
    return 16'(crc(44'(m), 32, {DCRC_POLY, 16'h0}, 32'hffff0000) >> 16);
  endfunction

  function automatic logic [15:0] lfsrStep(input logic [15:0] l);
    return {l[14:0], 1'b0} ^ (l[15] ? LFSR_TAPS : 16'h0000);
  endfunction

  // receive side: descramble, check and queue what the device sends
  always @(negedge clk_sys) begin
    w = linkTx.data ^ {rxLfsr, rxLfsr};
    if (linkTx.kind == KD_TS)
      rxLfsr <= LFSR_SEED;
    if (linkTx.kind == KD_SKIP)
      skips <= skips + 1;
    if (linkTx.kind == KD_TLP || linkTx.kind == KD_DLLP)
      rxLfsr <= lfsrStep(rxLfsr);
    if (linkTx.kind == KD_TLP)
      tq.push_back({linkTx.seq, w, linkTx.crc ^ crc({linkTx.seq, w}, 44, LCRC_POLY, '1)});
    if (linkTx.kind == KD_DLLP) begin
      if (linkTx.crc !== {16'h0, crc16(w)})
        w = ~w;
      if (w[31:24] == DL_FC)
        fcWord <= w;
      else
        dq.push_back(w);
    end
  end

  // one beat per call, back to back when called in a row
  task automatic send(input dlr_kind_t k, input logic [11:0] s, input logic [31:0] d, input logic bad);
    @(negedge clk_sys);
    linkRx.kind = k;
    linkRx.seq  = s;
    linkRx.data = d ^ {txLfsr, txLfsr};
    linkRx.crc  = ((k == KD_TLP) ? crc({s, d}, 44, LCRC_POLY, '1) : {16'h0, crc16(d)}) ^ {31'h0, bad};
    txLfsr      = (k == KD_TS) ? LFSR_SEED : lfsrStep(txLfsr);
  endtask

  // released line shows inverted leftovers, never a stale copy
  task automatic quiet();
    @(negedge clk_sys);
    linkRx = {KD_IDLE, ~linkRx.seq, ~linkRx.data, ~linkRx.crc};
  endtask
endmodule

// ---- dlr_link_bench.sv ----
`timescale 1ns/1ns
module dlr_link_bench;
  import dlr_pkg::*;
  logic              clk_sys     = 1'b0;
  logic              rst_b       = 1'b0;
  logic              tlTxValid   = 1'b0;
  logic [DATA_W-1:0] tlTxData    = '0;
  logic              tlTxReady;
  logic              tlRxValid;
  logic [DATA_W-1:0] tlRxData;
  logic              tlRxReady   = 1'b0;
  logic [CRED_W-1:0] rxCreditAdv = 8'h5a;
  logic [CRED_W-1:0] txCreditLimit;
  dlr_beat_t         linkTx;
  dlr_beat_t         linkRx;
  logic              linkUp;
  logic              replayActive;
  logic              sawReplay   = 1'b0;
  int                num_errors  = 0;
  int                num_checks  = 0;
  int                cyc         = 0;
  int                t0          = 0;

  always #50 clk_sys = ~clk_sys;

  dlr_link i_dlr_link (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .tlTxValid(tlTxValid), .tlTxData(tlTxData), .tlTxReady(tlTxReady),
    .tlRxValid(tlRxValid), .tlRxData(tlRxData), .tlRxReady(tlRxReady),
    .rxCreditAdv(rxCreditAdv), .txCreditLimit(txCreditLimit),
    .linkTx(linkTx), .linkRx(linkRx), .linkUp(linkUp), .replayActive(replayActive)
  );

  dlr_partner i_dlr_partner (.clk_sys(clk_sys), .linkTx(linkTx), .linkRx(linkRx));

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hang is cut short well past the expected run of somewhat over a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (replayActive === 1'b1)
      sawReplay <= 1'b1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // valid stays up after the taking edge; caller drops it or offers the next word
  task automatic put(input logic [31:0] d);
    @(negedge clk_sys);
    tlTxValid = 1'b1;
    tlTxData  = d;
    for (int n = 0; n < 900; n++) begin
      #10;
      if (tlTxReady === 1'b1)
        break;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask

  task automatic expTlp(input logic [11:0] s, input logic [31:0] d);
    for (int n = 0; n < 300 && i_dlr_partner.tq.size() == 0; n++) @(negedge clk_sys);
    chk(i_dlr_partner.tq.size() ? i_dlr_partner.tq.pop_front() : '1, {s, d, 32'h0});
  endtask

  task automatic expDl(input logic [31:0] d);
    for (int n = 0; n < 300 && i_dlr_partner.dq.size() == 0; n++) @(negedge clk_sys);
    chk(i_dlr_partner.dq.size() ? i_dlr_partner.dq.pop_front() : '1, d);
  endtask

  task automatic get(input logic [31:0] d);
    for (int n = 0; n < 50 && tlRxValid !== 1'b1; n++) @(negedge clk_sys);
    chk(tlRxData, d);
    tlRxReady = 1'b1;
    @(negedge clk_sys);
    tlRxReady = 1'b0;
  endtask

  task automatic t_reset();
    repeat (20) @(negedge clk_sys);
    chk({linkTx, tlTxReady, tlRxValid, txCreditLimit, linkUp, replayActive}, '0);
    rst_b = 1'b1;
  endtask

  task automatic t_train();
    for (int n = 0; n < 20 && linkTx.kind !== KD_TS; n++) @(negedge clk_sys);
    chk(linkTx.kind, KD_TS);
    i_dlr_partner.send(KD_TS, 12'h000, 32'h0, 1'b0);
    i_dlr_partner.send(KD_DLLP, 12'h000, {DL_FC, 16'h0, 8'h04}, 1'b0);
    i_dlr_partner.quiet();
    for (int n = 0; n < 50 && linkUp !== 1'b1; n++) @(negedge clk_sys);
    chk(linkUp, 1'b1);
    chk(txCreditLimit, 8'h04);
    for (int n = 0; n < 50 && i_dlr_partner.fcWord[31:24] !== DL_FC; n++) @(negedge clk_sys);
    chk(i_dlr_partner.fcWord, {DL_FC, 16'h0, rxCreditAdv});
  endtask

  task automatic t_retry();
    for (int i = 0; i < 4; i++) put(32'hc0de0000 + i);
    @(negedge clk_sys);
    tlTxValid = 1'b0;
    tlTxData  = 32'hc0de0004;
    #10;
    chk(tlTxReady, 1'b0);
    for (int i = 0; i < 4; i++) expTlp(12'(i), 32'hc0de0000 + i);
    i_dlr_partner.send(KD_DLLP, 12'h000, {DL_NAK, 12'h0, 12'h001}, 1'b0);
    i_dlr_partner.quiet();
    expTlp(12'h002, 32'hc0de0002);
    expTlp(12'h003, 32'hc0de0003);
    chk(sawReplay, 1'b1);
    i_dlr_partner.send(KD_DLLP, 12'h000, {DL_ACK, 12'h0, 12'h003}, 1'b0);
    i_dlr_partner.quiet();
    repeat (10) @(negedge clk_sys);
    chk(tlTxReady, 1'b0);
    i_dlr_partner.send(KD_DLLP, 12'h000, {DL_FC, 16'h0, 8'h08}, 1'b0);
    i_dlr_partner.quiet();
    put(32'hc0de0004);
    t0 = cyc;
    @(negedge clk_sys);
    tlTxValid = 1'b0;
    expTlp(12'h004, 32'hc0de0004);
    i_dlr_partner.send(KD_DLLP, 12'h000, {DL_ACK, 12'h0, 12'h004}, 1'b1);
    i_dlr_partner.quiet();
    expTlp(12'h004, 32'hc0de0004);
    chk((cyc - t0) inside {[180:230]}, 1'b1);
    i_dlr_partner.send(KD_DLLP, 12'h000, {DL_ACK, 12'h0, 12'h004}, 1'b0);
    i_dlr_partner.quiet();
    repeat (250) @(negedge clk_sys);
    chk(i_dlr_partner.tq.size(), 0);
  endtask

  // receiver stalls so the two-entry buffer fills and the third word is refused
  task automatic t_rx();
    i_dlr_partner.send(KD_TLP, 12'h000, 32'h5eed0000, 1'b0);
    i_dlr_partner.quiet();
    expDl({DL_ACK, 12'h0, 12'h000});
    i_dlr_partner.send(KD_TLP, 12'h001, 32'h5eed0001, 1'b1);
    i_dlr_partner.quiet();
    expDl({DL_NAK, 12'h0, 12'h000});
    i_dlr_partner.send(KD_TLP, 12'h001, 32'h5eed0001, 1'b0);
    i_dlr_partner.quiet();
    expDl({DL_ACK, 12'h0, 12'h001});
    i_dlr_partner.send(KD_TLP, 12'h002, 32'h5eed0002, 1'b0);
    i_dlr_partner.quiet();
    expDl({DL_NAK, 12'h0, 12'h001});
    get(32'h5eed0000);
    get(32'h5eed0001);
    chk(tlRxValid, 1'b0);
    i_dlr_partner.send(KD_TLP, 12'h002, 32'h5eed0002, 1'b0);
    i_dlr_partner.quiet();
    expDl({DL_ACK, 12'h0, 12'h002});
    // a repeated old packet is not delivered again but still acknowledged
    i_dlr_partner.send(KD_TLP, 12'h001, 32'h5eed0001, 1'b0);
    i_dlr_partner.quiet();
    expDl({DL_ACK, 12'h0, 12'h002});
    get(32'h5eed0002);
  endtask

  task automatic t_skip();
    for (int n = 0; n < 1300 && i_dlr_partner.skips == 0; n++) @(negedge clk_sys);
    chk(i_dlr_partner.skips > 0, 1'b1);
  endtask

  initial begin
    t_reset();
    t_train();
    t_retry();
    t_rx();
    t_skip();
    wrap_up();
  end
endmodule
